// *** include/exec_pkg.sv ***
// Constants for the subtract, swap, exchange and xor datapath
package exec_pkg;
  // Opcodes and opcode families
  localparam logic [3:0] FAM_SUB = 4'h9;
  localparam logic [3:0] FAM_EXG = 4'hC;
  localparam logic [3:0] FAM_XOR = 4'h6;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [6:0] OP_DIG_HI = 7'h6B;
  localparam logic [7:0] OP_XOR_DIR_A = 8'h62;
  localparam logic [7:0] OP_XOR_DIR_IMM = 8'h63;
  // Instruction lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  // Direct address map
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_PORT = 8'h90;
  // Status word bit positions
  localparam int PSW_CY = 7;
  localparam int PSW_AUX = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OVF = 2;
  localparam int PSW_F1 = 1;
  // Values after reset
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [7:0] RAM_RESET = 8'h00;
  localparam logic [1:0] RS_RESET = 2'h0;
  localparam int RAM_DEPTH = 256;
  typedef enum {ST_IDLE, ST_SECOND} exec_state_t;
endpackage : exec_pkg

// *** include/alu_if.sv ***
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cy_in;
  logic [7:0] diff;
  logic [7:0] xor_res;
  logic cy_out;
  logic ac_out;
  logic ov_out;
  modport unit (input a, b, cy_in, output diff, xor_res, cy_out, ac_out,
                ov_out);
  modport core (output a, b, cy_in, input diff, xor_res, cy_out, ac_out,
                ov_out);
endinterface : alu_if
`default_nettype wire

// *** core/sub_xor_unit.sv ***
// Borrow subtractor and xor for the execution core
`timescale 1ns/100ps
`default_nettype none
module sub_xor_unit (
  // Operands and results
  alu_if.unit bus
);
  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] low7;

  always_comb begin
    full = 9'({1'b0, bus.a}) - 9'({1'b0, bus.b}) - 9'(bus.cy_in);
    low = 5'({1'b0, bus.a[3:0]}) - 5'({1'b0, bus.b[3:0]})
          - 5'(bus.cy_in);
    low7 = 8'({1'b0, bus.a[6:0]}) - 8'({1'b0, bus.b[6:0]})
           - 8'(bus.cy_in);
  end

  assign bus.diff = full[7:0];
  assign bus.cy_out = full[8];
  assign bus.ac_out = low[4];
  // Borrow into bit 7 against borrow out of bit 7
  assign bus.ov_out = low7[7] ^ full[8];
  assign bus.xor_res = bus.a ^ bus.b;
endmodule : sub_xor_unit
`default_nettype wire

// *** core/exec_core.sv ***
// Execution core for borrow subtract, nibble swap, exchanges and xor
// Operation
// - Subtract with borrow puts A minus source minus carry into A.
// - Carry is set when bit 7 needs a borrow, cleared otherwise.
// - Auxiliary carry is set when bit 3 needs a borrow, else cleared.
// - Overflow is set when exactly one of the borrows into and out of bit 7 occurs.
// - Register-source subtract is 10011rrr, one byte, one cycle.
// - Direct-source subtract is 0x95 plus an address, one cycle.
// - Indirect subtract reads RAM at pointer 0 or 1, one byte, one cycle.
// - Immediate subtract is 0x94 plus a data byte, one cycle.
// - Nibble swap trades A halves, leaves flags, one byte, one cycle.
// - Exchange swaps A with a register, direct or indirect byte.
// - Digit exchange swaps low nibbles of A and the pointed RAM byte.
// - Xor stores the bitwise xor in the destination, flags untouched.
// - Xor into the port takes the old value from the output latch.
// - Xor into A takes register, direct, indirect or immediate source.
// - Xor of A into a direct byte is 0x62 plus an address, one cycle.
// - Xor of data into a direct byte is three bytes and two cycles.
`timescale 1ns/100ps
`default_nettype none
module exec_core (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Instruction from the decoder
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_byte2,
  input wire logic [7:0] i_byte3,
  // Port pins
  input wire logic [7:0] i_port_pins,
  // Memory peek
  input wire logic [7:0] i_peek_addr,
  // Status
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output logic [1:0] o_length,
  // Architectural state
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic o_aux_carry,
  output logic o_overflow,
  output logic o_parity,
  output logic [7:0] o_psw,
  output logic [7:0] o_port_latch,
  output logic [7:0] o_peek_data
);
  alu_if alu ();

  exec_pkg::exec_state_t state_q;
  logic busy_q;
  logic done_q;
  logic illegal_q;
  logic [1:0] len_q;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic cy_q;
  logic ac_q;
  logic ov_q;
  logic par_q;
  logic f0_q;
  logic f1_q;
  logic [1:0] rs_q;
  logic [7:0] latch_q;
  logic [7:0] pin_meta_q;
  logic [7:0] pin_q;
  logic [7:0] ram_q [exec_pkg::RAM_DEPTH];
  logic [7:0] addr2_q;
  logic [7:0] data3_q;
  logic [7:0] peek_q;

  logic [3:0] fam;
  logic [3:0] lo;
  logic [7:0] reg_addr;
  logic [7:0] ptr_addr;
  logic [7:0] ind_addr;
  logic [7:0] src;
  logic [7:0] raw_addr;
  logic go;
  logic flag_we;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_data;
  logic dir_we;
  logic [7:0] dir_addr;
  logic [7:0] dir_data;
  logic fin;
  logic bad;
  logic to_second;
  logic [1:0] len_d;

  sub_xor_unit u_unit (
    .bus(alu.unit)
  );

  // Status word as seen on the direct bus
  function automatic logic [7:0] psw_byte();
    return {cy_q, ac_q, f0_q, rs_q, ov_q, f1_q, par_q};
  endfunction : psw_byte

  // Direct read; rmw selects the port latch instead of the pins
  function automatic logic [7:0] read_dir(input logic [7:0] addr,
                                          input logic rmw);
    logic [7:0] v;
    v = 8'h00;
    if (!addr[7]) begin
      v = ram_q[addr];
    end else if (addr == exec_pkg::ADDR_ACC) begin
      v = acc_q;
    end else if (addr == exec_pkg::ADDR_PSW) begin
      v = psw_byte();
    end else if (addr == exec_pkg::ADDR_PORT) begin
      v = rmw ? latch_q : pin_q;
    end
    return v;
  endfunction : read_dir

  // Operand fetch shared by all one-byte-opcode families
  always_comb begin
    fam = i_opcode[7:4];
    lo = i_opcode[3:0];
    reg_addr = {3'b000, rs_q, i_opcode[2:0]};
    ptr_addr = {3'b000, rs_q, 2'b00, i_opcode[0]};
    ind_addr = ram_q[ptr_addr];
    raw_addr = lo[3] ? reg_addr : ind_addr;
    if (lo[3]) begin
      src = ram_q[reg_addr];
    end else if (lo == exec_pkg::LO_DIR) begin
      src = read_dir(i_byte2, 1'b0);
    end else if (lo[1]) begin
      src = ram_q[ind_addr];
    end else begin
      src = i_byte2;
    end
  end

  assign alu.a = acc_q;
  assign alu.b = (state_q == exec_pkg::ST_SECOND) ? data3_q : src;
  assign alu.cy_in = cy_q;
  assign go = i_start && !busy_q;

  // Decode and write selection
  always_comb begin
    acc_d = acc_q;
    flag_we = 1'b0;
    ram_we = 1'b0;
    ram_addr = raw_addr;
    ram_data = acc_q;
    dir_we = 1'b0;
    dir_addr = i_byte2;
    dir_data = acc_q;
    fin = 1'b0;
    bad = 1'b0;
    to_second = 1'b0;
    len_d = (lo == exec_pkg::LO_IMM || lo == exec_pkg::LO_DIR) ?
            exec_pkg::LEN_TWO : exec_pkg::LEN_ONE;
    if (state_q == exec_pkg::ST_SECOND) begin
      dir_we = 1'b1;
      dir_addr = addr2_q;
      dir_data = read_dir(addr2_q, 1'b1) ^ data3_q;
      fin = 1'b1;
      len_d = exec_pkg::LEN_THREE;
    end else if (go) begin
      fin = 1'b1;
      if (fam == exec_pkg::FAM_SUB && lo >= exec_pkg::LO_IMM) begin
        acc_d = alu.diff;
        flag_we = 1'b1;
      end else if (i_opcode == exec_pkg::OP_SWAP) begin
        acc_d = {acc_q[3:0], acc_q[7:4]};
        len_d = exec_pkg::LEN_ONE;
      end else if (fam == exec_pkg::FAM_EXG && lo > exec_pkg::LO_IMM) begin
        acc_d = src;
        if (lo == exec_pkg::LO_DIR) begin
          dir_we = 1'b1;
        end else begin
          ram_we = 1'b1;
        end
      end else if (i_opcode[7:1] == exec_pkg::OP_DIG_HI) begin
        acc_d = {acc_q[7:4], src[3:0]};
        ram_we = 1'b1;
        ram_data = {src[7:4], acc_q[3:0]};
      end else if (fam == exec_pkg::FAM_XOR && lo >= exec_pkg::LO_IMM) begin
        acc_d = alu.xor_res;
      end else if (i_opcode == exec_pkg::OP_XOR_DIR_A) begin
        dir_we = 1'b1;
        dir_data = read_dir(i_byte2, 1'b1) ^ acc_q;
        len_d = exec_pkg::LEN_TWO;
      end else if (i_opcode == exec_pkg::OP_XOR_DIR_IMM) begin
        fin = 1'b0;
        to_second = 1'b1;
        len_d = exec_pkg::LEN_THREE;
      end else begin
        fin = 1'b0;
        bad = 1'b1;
        len_d = exec_pkg::LEN_ONE;
      end
    end
    // Direct writes to the accumulator address land here too
    if (dir_we && dir_addr == exec_pkg::ADDR_ACC) begin
      acc_d = dir_data;
    end
  end

  // Sequencer; only the three-byte xor needs a second cycle
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_q <= exec_pkg::ST_IDLE;
      busy_q <= 1'b0;
      addr2_q <= 8'h00;
      data3_q <= 8'h00;
    end else begin
      case (state_q)
        exec_pkg::ST_IDLE: begin
          if (to_second) begin
            state_q <= exec_pkg::ST_SECOND;
            busy_q <= 1'b1;
            addr2_q <= i_byte2;
            data3_q <= i_byte3;
          end
        end
        exec_pkg::ST_SECOND: begin
          // Starts offered now are refused, so always back to idle
          state_q <= exec_pkg::ST_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= exec_pkg::ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Completion report
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      len_q <= exec_pkg::LEN_ONE;
    end else begin
      done_q <= fin;
      illegal_q <= bad;
      if (fin || bad) begin
        len_q <= len_d;
      end
    end
  end

  // Accumulator with parity tracking it every cycle
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      acc_q <= exec_pkg::ACC_RESET;
      par_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      par_q <= ^acc_d;
    end
  end

  // Flags; a direct write to the status word wins over the subtract
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cy_q <= 1'b0;
      ac_q <= 1'b0;
      ov_q <= 1'b0;
      f0_q <= 1'b0;
      f1_q <= 1'b0;
      rs_q <= exec_pkg::RS_RESET;
    end else if (dir_we && dir_addr == exec_pkg::ADDR_PSW) begin
      cy_q <= dir_data[exec_pkg::PSW_CY];
      ac_q <= dir_data[exec_pkg::PSW_AUX];
      f0_q <= dir_data[exec_pkg::PSW_F0];
      rs_q <= {dir_data[exec_pkg::PSW_RS1], dir_data[exec_pkg::PSW_RS0]};
      ov_q <= dir_data[exec_pkg::PSW_OVF];
      f1_q <= dir_data[exec_pkg::PSW_F1];
    end else if (flag_we) begin
      cy_q <= alu.cy_out;
      ac_q <= alu.ac_out;
      ov_q <= alu.ov_out;
    end
  end

  // Port output latch
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      latch_q <= exec_pkg::PORT_RESET;
    end else if (dir_we && dir_addr == exec_pkg::ADDR_PORT) begin
      latch_q <= dir_data;
    end
  end

  // Pin synchroniser; pins are asynchronous to the core clock
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pin_meta_q <= 8'h00;
      pin_q <= 8'h00;
    end else begin
      pin_meta_q <= i_port_pins;
      pin_q <= pin_meta_q;
    end
  end

  // Internal RAM; bank registers live in its lowest 32 bytes
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < exec_pkg::RAM_DEPTH; k++) begin
        ram_q[k] <= exec_pkg::RAM_RESET;
      end
    end else if (ram_we) begin
      ram_q[ram_addr] <= ram_data;
    end else if (dir_we && !dir_addr[7]) begin
      ram_q[dir_addr] <= dir_data;
    end
  end

  // Registered peek so the bench can inspect RAM
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      peek_q <= 8'h00;
    end else begin
      peek_q <= ram_q[i_peek_addr];
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_illegal = illegal_q;
  assign o_length = len_q;
  assign o_acc = acc_q;
  assign o_carry = cy_q;
  assign o_aux_carry = ac_q;
  assign o_overflow = ov_q;
  assign o_parity = par_q;
  // Spelled out: a call without arguments is never re-evaluated here
  assign o_psw = {cy_q, ac_q, f0_q, rs_q, ov_q, f1_q, par_q};
  assign o_port_latch = latch_q;
  assign o_peek_data = peek_q;
endmodule : exec_core
`default_nettype wire

// *** tb/exec_core_sva.sv ***
// Checker for the execution core ports
`timescale 1ns/100ps
`default_nettype none
module exec_core_sva (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Instruction
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_byte2,
  // Status and state
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic [1:0] o_length,
  input wire logic [7:0] o_acc,
  input wire logic o_carry,
  input wire logic o_aux_carry,
  input wire logic o_overflow,
  input wire logic [7:0] o_psw
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  logic go;
  logic [8:0] dif;
  logic [4:0] nib;
  logic [7:0] low7;
  assign go = i_start && !o_busy;
  // Immediate subtract reference, borrows taken from widened differences
  assign dif = {1'b0, o_acc} - {1'b0, i_byte2} - 9'(o_carry);
  assign nib = {1'b0, o_acc[3:0]} - {1'b0, i_byte2[3:0]} - 5'(o_carry);
  assign low7 = {1'b0, o_acc[6:0]} - {1'b0, i_byte2[6:0]} - 8'(o_carry);
  property p_one_cycle;
    go && i_opcode != exec_pkg::OP_XOR_DIR_IMM |=> o_done ^ o_illegal;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("one-cycle op not finished");
  property p_two_cycle;
    go && i_opcode == exec_pkg::OP_XOR_DIR_IMM |=> o_busy && !o_done
      ##1 !o_busy && o_done && o_length == exec_pkg::LEN_THREE;
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("two-cycle xor timing wrong");
  property p_sub_acc;
    go && i_opcode == 8'h94 |=> o_acc == $past(dif[7:0]);
  endproperty
  a_sub_acc: assert property (p_sub_acc)
    else $error("subtract result wrong");
  property p_sub_cy;
    go && i_opcode == 8'h94 |=> o_carry == $past(dif[8]);
  endproperty
  a_sub_cy: assert property (p_sub_cy)
    else $error("subtract carry wrong");
  property p_sub_ac;
    go && i_opcode == 8'h94 |=> o_aux_carry == $past(nib[4]);
  endproperty
  a_sub_ac: assert property (p_sub_ac)
    else $error("subtract aux carry wrong");
  property p_sub_ov;
    go && i_opcode == 8'h94 |=> o_overflow == $past(low7[7] ^ dif[8]);
  endproperty
  a_sub_ov: assert property (p_sub_ov)
    else $error("subtract overflow wrong");
  property p_swap;
    go && i_opcode == exec_pkg::OP_SWAP |=> o_psw[7:1] == $past(o_psw[7:1])
      && o_acc == {$past(o_acc[3:0]), $past(o_acc[7:4])};
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");
  property p_xor_imm;
    go && i_opcode == 8'h64 |=> o_acc == $past(o_acc ^ i_byte2)
      && o_psw[7:1] == $past(o_psw[7:1]);
  endproperty
  a_xor_imm: assert property (p_xor_imm)
    else $error("xor into acc wrong");
  property p_digit;
    go && i_opcode[7:1] == exec_pkg::OP_DIG_HI |=> o_acc[7:4] ==
      $past(o_acc[7:4]) && o_psw[7:1] == $past(o_psw[7:1]);
  endproperty
  a_digit: assert property (p_digit)
    else $error("digit exchange touched high nibble or flags");
  property p_parity;
    o_psw[0] == ^o_acc;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity does not follow acc");
endmodule : exec_core_sva
bind exec_core exec_core_sva u_exec_core_sva (.i_clock(i_clock),
  .i_reset(i_reset), .i_start(i_start), .i_opcode(i_opcode),
  .i_byte2(i_byte2), .o_busy(o_busy), .o_done(o_done),
  .o_illegal(o_illegal), .o_length(o_length), .o_acc(o_acc),
  .o_carry(o_carry), .o_aux_carry(o_aux_carry),
  .o_overflow(o_overflow), .o_psw(o_psw));
`default_nettype wire

// *** tb/exec_core_tb.sv ***
// Self-checking bench for the execution core
`timescale 1ns/100ps
`default_nettype none
module exec_core_tb;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_start = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [7:0] i_byte2 = 8'h00;
  logic [7:0] i_byte3 = 8'h00;
  // Pins differ from the latch so a pin read would show
  logic [7:0] i_port_pins = 8'h3C;
  logic [7:0] i_peek_addr = 8'h20;
  logic o_busy, o_done, o_illegal, o_carry, o_aux_carry, o_overflow;
  logic o_parity;
  logic [1:0] o_length;
  logic [7:0] o_acc, o_psw, o_port_latch, o_peek_data;
  int err_total = 0;
  int checks_done = 0;
  always #5 i_clock = ~i_clock;
  exec_core u_exec_core (.i_clock(i_clock), .i_reset(i_reset),
    .i_start(i_start), .i_opcode(i_opcode), .i_byte2(i_byte2),
    .i_byte3(i_byte3), .i_port_pins(i_port_pins),
    .i_peek_addr(i_peek_addr), .o_busy(o_busy), .o_done(o_done),
    .o_illegal(o_illegal), .o_length(o_length), .o_acc(o_acc),
    .o_carry(o_carry), .o_aux_carry(o_aux_carry),
    .o_overflow(o_overflow), .o_parity(o_parity), .o_psw(o_psw),
    .o_port_latch(o_port_latch), .o_peek_data(o_peek_data));
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task run(input logic [7:0] c, b2, b3, input logic [1:0] l,
           input logic [7:0] ea, ep);
    @(negedge i_clock);
    i_start = 1'b1;
    i_opcode = c;
    i_byte2 = b2;
    i_byte3 = b3;
    @(negedge i_clock);
    if (c == 8'h63) begin
      // A swap offered while busy must be ignored
      i_opcode = 8'hC4;
      chk("busy", 8'h01, {7'h00, o_busy});
      @(negedge i_clock);
    end
    i_start = 1'b0;
    chk("end", (c == 8'h00) ? 8'h01 : 8'h02, {6'h00, o_done, o_illegal});
    chk("length", {6'h00, l}, {6'h00, o_length});
    chk("acc", ea, o_acc);
    chk("psw", ep, o_psw);
    chk("flags", {4'h0, ep[7], ep[6], ep[2], ep[0]},
        {4'h0, o_carry, o_aux_carry, o_overflow, o_parity});
  endtask : run
  task pk(input logic [7:0] a, exp);
    @(negedge i_clock);
    i_peek_addr = a;
    @(negedge i_clock);
    chk("ram", exp, o_peek_data);
  endtask : pk
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  initial begin
    #20000;
    err_total++;
    test_done;
  end
  initial begin
    repeat (5) @(negedge i_clock);
    i_reset = 1'b0;
    chk("acc", 8'h00, o_acc);
    chk("psw", 8'h00, o_psw);
    chk("port", 8'hFF, o_port_latch);
    run(8'h64, 8'h54, 8'h00, 2'h2, 8'h54, 8'h01);
    run(8'hC5, 8'h02, 8'h00, 2'h2, 8'h00, 8'h00);
    run(8'h64, 8'hC9, 8'h00, 2'h2, 8'hC9, 8'h00);
    run(8'h63, 8'hD0, 8'h80, 2'h3, 8'hC9, 8'h80);
    run(8'h9A, 8'h00, 8'h00, 2'h1, 8'h74, 8'h04);
    run(8'h94, 8'h75, 8'h00, 2'h2, 8'hFF, 8'hC0);
    run(8'h64, 8'h3A, 8'h00, 2'h2, 8'hC5, 8'hC0);
    run(8'hC4, 8'h00, 8'h00, 2'h1, 8'h5C, 8'hC0);
    run(8'h64, 8'h29, 8'h00, 2'h2, 8'h75, 8'hC1);
    run(8'hC5, 8'h20, 8'h00, 2'h2, 8'h00, 8'hC0);
    run(8'h64, 8'h20, 8'h00, 2'h2, 8'h20, 8'hC1);
    run(8'hC8, 8'h00, 8'h00, 2'h1, 8'h00, 8'hC0);
    run(8'h64, 8'h36, 8'h00, 2'h2, 8'h36, 8'hC0);
    run(8'hD6, 8'h00, 8'h00, 2'h1, 8'h35, 8'hC0);
    pk(8'h20, 8'h76);
    run(8'hC6, 8'h00, 8'h00, 2'h1, 8'h76, 8'hC1);
    pk(8'h20, 8'h35);
    run(8'h66, 8'h00, 8'h00, 2'h1, 8'h43, 8'hC1);
    run(8'h96, 8'h00, 8'h00, 2'h1, 8'h0D, 8'h41);
    run(8'h62, 8'h90, 8'h00, 2'h2, 8'h0D, 8'h41);
    chk("port", 8'hF2, o_port_latch);
    // A direct source read of the port sees the synchronised pins
    run(8'h65, 8'h90, 8'h00, 2'h2, 8'h31, 8'h41);
    // Select bank 3 through the status word, then use it
    run(8'h63, 8'hD0, 8'h18, 2'h3, 8'h31, 8'h59);
    run(8'hCB, 8'h00, 8'h00, 2'h1, 8'h00, 8'h58);
    pk(8'h1B, 8'h31);
    run(8'h95, 8'h02, 8'h00, 2'h2, 8'hAC, 8'hD8);
    run(8'h00, 8'h00, 8'h00, 2'h1, 8'hAC, 8'hD8);
    test_done;
  end
endmodule : exec_core_tb
`default_nettype wire
